//--- ldpic_top.sv
// LED driver power-up sequencing, supply warning and channel current setup
`timescale 1ns/1ps
`default_nettype none
`include "ldpic_map.svh"
module ldpic_top
	import ldpic_pkg::*;
#(
	parameter int CONV_CYC  = `LDPIC_CONV_CYC,
	parameter int DIAG_CYC  = `LDPIC_DIAG_CYC,
	parameter int ISTEP_CYC = `LDPIC_ISTEP_CYC
) (
	input  wire logic                                      clk_in,
	input  wire logic                                      sys_rst_in,
	input  wire logic                                      supply_uv_in,
	input  wire logic                                      ldo_uv_in,
	input  wire logic [`LDPIC_ILEN_W-1:0]                  nv_init_timer_length_in,
	input  wire logic [1:0]                                nv_reference_range_in,
	input  wire logic [`LDPIC_NCH*`LDPIC_CODE_W-1:0]       nv_current_code_in,
	input  wire logic [`LDPIC_THR_W-1:0]                   nv_low_supply_threshold_in,
	input  wire logic [`LDPIC_PW_W-1:0]                    nv_diag_pulse_width_in,
	input  wire logic                                      reset_flag_clear_cmd_in,
	input  wire logic                                      register_reload_cmd_in,
	input  wire logic                                      fault_clear_cmd_in,
	input  wire logic                                      range_wr_in,
	input  wire logic [1:0]                                reference_range_select_in,
	input  wire logic                                      enable_wr_in,
	input  wire logic [`LDPIC_NCH-1:0]                     channel_enable_bit_in,
	input  wire logic                                      code_wr_in,
	input  wire logic [3:0]                                code_channel_in,
	input  wire logic [`LDPIC_CODE_W-1:0]                  channel_current_code_in,
	input  wire logic                                      threshold_wr_in,
	input  wire logic [`LDPIC_THR_W-1:0]                   low_supply_threshold_in,
	input  wire logic                                      pulse_width_wr_in,
	input  wire logic [`LDPIC_PW_W-1:0]                    diag_pulse_width_sel_in,
	input  wire logic                                      diag_start_in,
	input  wire logic                                      adc_other_req_in,
	input  wire logic [`LDPIC_ADC_W-1:0]                   adc_supply_code_in,
	output ldpic_state_type                                state_out,
	output logic                                           reset_flag_out,
	output logic                                           register_reload_cmd_out,
	output logic                                           reset_flag_clear_cmd_out,
	output logic                                           fault_clear_cmd_out,
	output logic                                           low_supply_warning_flag_out,
	output logic                                           open_diag_enable_out,
	output logic                                           short_diag_enable_out,
	output logic [`LDPIC_ADC_W-1:0]                        supply_result_out,
	output logic [1:0]                                     reference_range_select_out,
	output logic [`LDPIC_MULT_W-1:0]                       full_range_mult_out,
	output logic [`LDPIC_NCH-1:0]                          channel_enable_out,
	output logic [`LDPIC_NCH*`LDPIC_CODE_W-1:0]            channel_current_code_out,
	output logic [`LDPIC_THR_W-1:0]                        low_supply_threshold_out,
	output logic [`LDPIC_PW_W-1:0]                         diag_pulse_width_sel_out,
	output logic                                           diag_pulse_out,
	output logic                                           err_out,
	output logic                                           err_oe_out
);
	// ****************************************************************
	// Functions
	// ****************************************************************
	// Range field to full-range multiplier
	function automatic logic [`LDPIC_MULT_W-1:0] range_mult(input logic [1:0] sel);
		case (sel)
			`LDPIC_RANGE_512: range_mult = `LDPIC_MULT_512;
			`LDPIC_RANGE_256: range_mult = `LDPIC_MULT_256;
			`LDPIC_RANGE_128: range_mult = `LDPIC_MULT_128;
			default:          range_mult = `LDPIC_MULT_64;
		endcase
	endfunction

	// Threshold setting to supply result code
	function automatic logic [`LDPIC_ADC_W-1:0] thr_code(input logic [`LDPIC_THR_W-1:0] t);
		thr_code = `LDPIC_ADC_W'(`LDPIC_LSUP_BASE + `LDPIC_LSUP_STEP * (t - 1'b1));
	endfunction

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic                      s_uv1_q;
	logic                      s_uv2_q;
	logic                      l_uv1_q;
	logic                      l_uv2_q;
	ldpic_state_type           state_q;
	ldpic_state_type           state_d;
	logic                      por_flag_q;
	logic                      reload_q;
	logic [`LDPIC_INIT_CNT_W-1:0] init_cnt_q;
	logic [1:0]                range_q;
	logic [`LDPIC_NCH-1:0]     en_q;
	logic [`LDPIC_CODE_W-1:0]  code_q [`LDPIC_NCH];
	logic [`LDPIC_THR_W-1:0]   thr_q;
	logic [`LDPIC_PW_W-1:0]    pw_q;
	logic                      low_flag_q;
	logic                      below_q;
	logic [`LDPIC_DIAG_CNT_W-1:0] diag_cnt_q;
	logic                      diag_q;
	logic [`LDPIC_ADC_W-1:0]   adc_result;
	logic                      adc_valid;

	// ****************************************************************
	// Decoding
	// ****************************************************************
	logic                         uv_any;
	logic                         in_reset;
	logic                         load_dflt;
	logic                         init_done;
	logic                         flag_set;
	logic                         below_now;
	logic [`LDPIC_INIT_CNT_W-1:0] init_len;
	logic [`LDPIC_DIAG_CNT_W-1:0] diag_len;

	// Supply monitor and register default load conditions
	assign uv_any    = s_uv2_q || l_uv2_q;
	assign in_reset  = (state_q == LDPIC_ST_RESET);
	assign load_dflt = in_reset || uv_any || reload_q;
	assign init_len  = `LDPIC_INIT_CNT_W'(ISTEP_CYC * nv_init_timer_length_in);
	assign init_done = (init_cnt_q >= init_len);
	assign flag_set  = in_reset || reload_q;
	assign below_now = (thr_q != `LDPIC_THR_OFF) && (adc_result < thr_code(thr_q));
	assign diag_len  = `LDPIC_DIAG_CNT_W'(DIAG_CYC * (pw_q + 1));

	// Undervoltage pins pass two flops
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_uv1_q <= 1'b1;
			s_uv2_q <= 1'b1;
			l_uv1_q <= 1'b1;
			l_uv2_q <= 1'b1;
		end else begin
			s_uv1_q <= supply_uv_in;
			s_uv2_q <= s_uv1_q;
			l_uv1_q <= ldo_uv_in;
			l_uv2_q <= l_uv1_q;
		end
	end

	// ****************************************************************
	// Power state sequence
	// ****************************************************************
	// Next state of reset, init and normal
	always_comb begin
		state_d = state_q;
		case (state_q)
			LDPIC_ST_RESET: begin
				state_d = uv_any ? LDPIC_ST_RESET : LDPIC_ST_INIT;
			end
			LDPIC_ST_INIT: begin
				if (reset_flag_clear_cmd_in || init_done) begin
					state_d = LDPIC_ST_NORMAL;
				end
			end
			LDPIC_ST_NORMAL: state_d = LDPIC_ST_NORMAL;
			default:         state_d = LDPIC_ST_RESET;
		endcase
		if (uv_any) begin
			state_d = LDPIC_ST_RESET;
		end
	end

	// State and init timer
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q    <= LDPIC_ST_RESET;
			init_cnt_q <= '0;
		end else begin
			state_q    <= state_d;
			init_cnt_q <= (state_q == LDPIC_ST_INIT) ? init_cnt_q + 1'b1 : '0;
		end
	end

	// Reset history flag; setting wins over clearing
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			por_flag_q <= 1'b1;
		end else if (flag_set) begin
			por_flag_q <= 1'b1;
		end else if (reset_flag_clear_cmd_in) begin
			por_flag_q <= 1'b0;
		end
	end

	// Reload command bit, cleared after one cycle of action
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reload_q <= 1'b0;
		end else begin
			reload_q <= register_reload_cmd_in && !reload_q && !in_reset;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// Range, enables, threshold and pulse width
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			range_q <= `LDPIC_RANGE_DFLT;
			en_q    <= `LDPIC_EN_DFLT;
			thr_q   <= `LDPIC_THR_OFF;
			pw_q    <= '0;
		end else if (load_dflt) begin
			range_q <= nv_reference_range_in;
			en_q    <= `LDPIC_EN_DFLT;
			thr_q   <= nv_low_supply_threshold_in;
			pw_q    <= nv_diag_pulse_width_in;
		end else begin
			if (range_wr_in) range_q <= reference_range_select_in;
			if (enable_wr_in) en_q <= channel_enable_bit_in;
			if (threshold_wr_in) thr_q <= low_supply_threshold_in;
			if (pulse_width_wr_in) pw_q <= diag_pulse_width_sel_in;
		end
	end

	// Per-channel current codes
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < `LDPIC_NCH; i++) code_q[i] <= '0;
		end else if (load_dflt) begin
			for (int i = 0; i < `LDPIC_NCH; i++) begin
				code_q[i] <= nv_current_code_in[i*`LDPIC_CODE_W +: `LDPIC_CODE_W];
			end
		end else if (code_wr_in && (code_channel_in < 4'(`LDPIC_NCH))) begin
			code_q[code_channel_in] <= channel_current_code_in;
		end
	end

	// ****************************************************************
	// Low-supply warning
	// ****************************************************************
	ldpic_adc_seq #(
		.CONV_CYC(CONV_CYC)
	) u_adc (
		.clk_in          (clk_in),
		.sys_rst_in      (sys_rst_in),
		.hold_in         (in_reset),
		.other_req_in    (adc_other_req_in),
		.supply_code_in  (adc_supply_code_in),
		.result_out      (adc_result),
		.result_valid_out(adc_valid)
	);

	// Compare each result; warning set wins over fault clear
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			below_q    <= 1'b0;
			low_flag_q <= 1'b0;
		end else if (in_reset) begin
			below_q    <= 1'b0;
			low_flag_q <= 1'b0;
		end else begin
			if (adc_valid) below_q <= below_now;
			if (adc_valid && below_now) begin
				low_flag_q <= 1'b1;
			end else if (fault_clear_cmd_in) begin
				low_flag_q <= 1'b0;
			end
		end
	end

	// Diagnostic pulse of selected width
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			diag_q     <= 1'b0;
			diag_cnt_q <= '0;
		end else if (in_reset) begin
			diag_q     <= 1'b0;
			diag_cnt_q <= '0;
		end else if (diag_q) begin
			diag_q     <= (diag_cnt_q < diag_len - 1'b1);
			diag_cnt_q <= diag_cnt_q + 1'b1;
		end else if (diag_start_in) begin
			diag_q     <= 1'b1;
			diag_cnt_q <= '0;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign state_out                   = state_q;
	assign reset_flag_out              = por_flag_q;
	assign register_reload_cmd_out     = reload_q;
	assign reset_flag_clear_cmd_out    = 1'b0;
	assign fault_clear_cmd_out         = 1'b0;
	assign low_supply_warning_flag_out = low_flag_q;
	assign open_diag_enable_out        = !below_q;
	assign short_diag_enable_out       = !below_q;
	assign supply_result_out           = adc_result;
	assign reference_range_select_out  = range_q;
	assign full_range_mult_out         = range_mult(range_q);
	assign channel_enable_out          = en_q;
	assign low_supply_threshold_out    = thr_q;
	assign diag_pulse_width_sel_out    = pw_q;
	assign diag_pulse_out              = diag_q;
	assign err_out                     = 1'b0;
	assign err_oe_out                  = in_reset;
	always_comb begin
		for (int i = 0; i < `LDPIC_NCH; i++) begin
			channel_current_code_out[i*`LDPIC_CODE_W +: `LDPIC_CODE_W] = code_q[i];
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_supplies_good;
		in_reset && !uv_any;
	endsequence
	sequence s_init_released;
		(state_q == LDPIC_ST_INIT) && !err_oe_out;
	endsequence
	a_uv_forces_reset: assert property (uv_any |=> in_reset)
		else $error("undervoltage did not force reset");
	a_flag_in_reset: assert property (in_reset |=> por_flag_q)
		else $error("history flag not set in reset");
	a_reset_outputs_off: assert property (in_reset |-> en_q == '0 && err_oe_out && !err_out)
		else $error("outputs not off in reset");
	a_reset_to_init: assert property (s_supplies_good |=> s_init_released)
		else $error("no init after supplies good");
	a_init_timer_end: assert property ((state_q == LDPIC_ST_INIT) && init_done && !uv_any
		|=> state_q == LDPIC_ST_NORMAL)
		else $error("init timer expiry ignored");
	a_init_early_exit: assert property ((state_q == LDPIC_ST_INIT) && !init_done
		&& !uv_any && !reset_flag_clear_cmd_in |=> state_q == LDPIC_ST_INIT)
		else $error("init left early");
	a_flag_clear_init: assert property ((state_q == LDPIC_ST_INIT)
		&& reset_flag_clear_cmd_in && !uv_any |=> state_q == LDPIC_ST_NORMAL && !por_flag_q)
		else $error("flag clear did not end init");
	a_default_load: assert property (load_dflt |=> range_q == $past(nv_reference_range_in)
		&& thr_q == $past(nv_low_supply_threshold_in))
		else $error("stored settings not loaded");
	a_enable_off: assert property (load_dflt |=> en_q == `LDPIC_EN_DFLT)
		else $error("channel enables not cleared");
	a_reload_flag: assert property (register_reload_cmd_in && !reload_q && !uv_any
		&& !in_reset |=> reload_q ##1 por_flag_q)
		else $error("reload did not set history flag");
	a_reload_selfclr: assert property (reload_q |=> !reload_q)
		else $error("reload bit stuck");
	a_low_flag_set: assert property (adc_valid && below_now && !in_reset |=> low_flag_q)
		else $error("low supply not flagged");
	a_low_flag_clr: assert property (low_flag_q && fault_clear_cmd_in && !adc_valid
		&& !in_reset |=> !low_flag_q)
		else $error("fault clear ignored");
	a_diag_suppress: assert property (below_q |-> !open_diag_enable_out && !short_diag_enable_out)
		else $error("diagnostics not suppressed");
	a_range_mult: assert property (range_q == `LDPIC_RANGE_512 |-> full_range_mult_out == 10'd512)
		else $error("range multiplier wrong");
	a_code_write: assert property (code_wr_in && !load_dflt
		&& code_channel_in < 4'(`LDPIC_NCH)
		|=> code_q[$past(code_channel_in)] == $past(channel_current_code_in))
		else $error("current code not written");
	a_diag_min_width: assert property ($rose(diag_q) && !in_reset |-> diag_q[*8])
		else $error("diagnostic pulse too short");
	a_diag_width_end: assert property (diag_q && !in_reset |-> diag_cnt_q < diag_len)
		else $error("diagnostic pulse too long");
endmodule // ldpic_top
`default_nettype wire

//--- ldpic_map.svh
// Constants for the LED driver power, init and current configuration block
`ifndef LDPIC_MAP_SVH
`define LDPIC_MAP_SVH
// ****************************************************************
// Widths
// ****************************************************************
`define LDPIC_NCH          12
`define LDPIC_CODE_W       6
`define LDPIC_ADC_W        8
`define LDPIC_THR_W        4
`define LDPIC_PW_W         4
`define LDPIC_ILEN_W       4
`define LDPIC_MULT_W       10
// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define LDPIC_RANGE_DFLT   2'b11
`define LDPIC_RANGE_512    2'b11
`define LDPIC_RANGE_256    2'b10
`define LDPIC_RANGE_128    2'b01
`define LDPIC_MULT_512     10'd512
`define LDPIC_MULT_256     10'd256
`define LDPIC_MULT_128     10'd128
`define LDPIC_MULT_64      10'd64
`define LDPIC_EN_DFLT      12'h000
`define LDPIC_THR_OFF      4'h0
`define LDPIC_LSUP_BASE    8'h30
`define LDPIC_LSUP_STEP    8'h0a
// ****************************************************************
// Timing, clock 100 MHz
// ****************************************************************
`define LDPIC_CLK_NS       10
`define LDPIC_T_CONV_US    57
`define LDPIC_T_DIAG_US    100
`define LDPIC_T_ISTEP_US   1000
`define LDPIC_CONV_CYC     ((`LDPIC_T_CONV_US * 1000) / `LDPIC_CLK_NS)
`define LDPIC_DIAG_CYC     ((`LDPIC_T_DIAG_US * 1000 + `LDPIC_CLK_NS - 1) / `LDPIC_CLK_NS)
`define LDPIC_ISTEP_CYC    ((`LDPIC_T_ISTEP_US * 1000) / `LDPIC_CLK_NS)
`define LDPIC_CONV_CNT_W   13
`define LDPIC_DIAG_CNT_W   18
`define LDPIC_INIT_CNT_W   21
`endif

//--- ldpic_pkg.sv
// Types of the LED driver power, init and current configuration block
package ldpic_pkg;
	typedef enum logic [1:0] {
		LDPIC_ST_RESET,
		LDPIC_ST_INIT,
		LDPIC_ST_NORMAL
	} ldpic_state_type;
endpackage

//--- ldpic_adc_seq.sv
// Supply conversion sequencer: timed conversions of the supply voltage
`timescale 1ns/1ps
`default_nettype none
`include "ldpic_map.svh"
module ldpic_adc_seq
	import ldpic_pkg::*;
#(
	parameter int CONV_CYC = `LDPIC_CONV_CYC
) (
	input  wire logic                    clk_in,
	input  wire logic                    sys_rst_in,
	input  wire logic                    hold_in,
	input  wire logic                    other_req_in,
	input  wire logic [`LDPIC_ADC_W-1:0] supply_code_in,
	output logic      [`LDPIC_ADC_W-1:0] result_out,
	output logic                         result_valid_out
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [`LDPIC_ADC_W-1:0]     code_s1_q;
	logic [`LDPIC_ADC_W-1:0]     code_s2_q;
	logic [`LDPIC_CONV_CNT_W-1:0] cnt_q;
	logic                        busy_q;
	logic                        done;
	logic                        start;
	localparam logic [`LDPIC_CONV_CNT_W-1:0] LAST = `LDPIC_CONV_CNT_W'(CONV_CYC - 1);

	// Conversion ends after the nominal conversion time; idle converter resamples supply
	assign done  = busy_q && (cnt_q == LAST);
	assign start = !busy_q && !other_req_in && !hold_in;

	// Analog code settles through two flops
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			code_s1_q <= '0;
			code_s2_q <= '0;
		end else begin
			code_s1_q <= supply_code_in;
			code_s2_q <= code_s1_q;
		end
	end

	// Conversion timer
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			busy_q <= 1'b0;
			cnt_q  <= '0;
		end else if (hold_in) begin
			busy_q <= 1'b0;
			cnt_q  <= '0;
		end else if (start) begin
			busy_q <= 1'b1;
			cnt_q  <= '0;
		end else if (busy_q) begin
			busy_q <= !done;
			cnt_q  <= done ? '0 : cnt_q + 1'b1;
		end
	end

	// Result register holds the latest supply conversion
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			result_out       <= '0;
			result_valid_out <= 1'b0;
		end else begin
			result_valid_out <= done;
			if (done) begin
				result_out <= code_s2_q;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_conv_length: assert property (@(posedge clk_in) disable iff (sys_rst_in || hold_in)
		$rose(busy_q) |-> (cnt_q == '0) ##1 (busy_q && !done)[*8])
		else $error("conversion ended too early");
	a_conv_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		done && !hold_in |=> result_valid_out && (result_out == $past(code_s2_q)))
		else $error("conversion result not stored");
endmodule // ldpic_adc_seq
`default_nettype wire

//--- ldpic_host_model.sv
// Host model: issues the register reload command on request
`timescale 1ns/1ps
`default_nettype none
module ldpic_host_model (
	input  wire logic clk_in,
	input  wire logic go_in,
	output logic      reload_out
);
	// Quiet until the first request
	initial reload_out = 1'b0;
	// One-cycle reload pulse per request on go_in; a reset alone issues nothing
	always @(posedge clk_in) begin
		reload_out <= go_in & ~reload_out;
	end
endmodule // ldpic_host_model
`default_nettype wire

//--- ldpic_top_tb.sv
// Testbench of the LED driver power, init and current configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ldpic_map.svh"
module ldpic_top_tb;
	import ldpic_pkg::*;
	logic clk_in = 0, sys_rst_in = 1, supply_uv_in = 0, ldo_uv_in = 0, go = 0;
	logic reset_flag_clear_cmd_in = 0, fault_clear_cmd_in = 0, range_wr_in = 0, enable_wr_in = 0;
	logic code_wr_in = 0, threshold_wr_in = 0, pulse_width_wr_in = 0, diag_start_in = 0;
	logic adc_other_req_in = 0;
	logic [1:0] nv_reference_range_in = 2'h2, reference_range_select_in = 2'h0;
	logic [3:0] nv_init_timer_length_in = 4'h1, nv_low_supply_threshold_in = 4'h0;
	logic [3:0] nv_diag_pulse_width_in = 4'h0, code_channel_in = 4'h0;
	logic [3:0] low_supply_threshold_in = 4'h0, diag_pulse_width_sel_in = 4'h0;
	logic [5:0] channel_current_code_in = 6'h00;
	logic [7:0] adc_supply_code_in = 8'hff, supply_result_out;
	logic [11:0] channel_enable_bit_in = 12'h000, channel_enable_out;
	logic [71:0] nv_current_code_in = 72'h0, channel_current_code_out;
	logic [9:0] full_range_mult_out;
	logic [3:0] low_supply_threshold_out, diag_pulse_width_sel_out;
	logic [1:0] reference_range_select_out;
	logic reset_flag_out, register_reload_cmd_out, reset_flag_clear_cmd_out, fault_clear_cmd_out;
	logic low_supply_warning_flag_out, open_diag_enable_out, short_diag_enable_out;
	logic diag_pulse_out, err_out, err_oe_out;
	ldpic_state_type state_out;
	wire logic register_reload_cmd_in;
	int errors = 0, checks = 0;
	ldpic_top #(.CONV_CYC(20), .DIAG_CYC(10), .ISTEP_CYC(4)) i_ldpic_top (.*);
	ldpic_host_model i_ldpic_host_model (.clk_in, .go_in(go), .reload_out(register_reload_cmd_in));
	// Clock, 100 MHz
	always #5 clk_in = ~clk_in;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Power-up, init, flag clear, then undervoltage and timed init
	task automatic t_power;
		step(5);
		chk(state_out, LDPIC_ST_RESET);
		chk({err_oe_out, reset_flag_out, channel_enable_out}, 16'h3000);
		chk(full_range_mult_out, 16'h200);
		sys_rst_in = 0;
		step(3);
		chk({state_out, err_oe_out}, {LDPIC_ST_INIT, 1'b0});
		chk(reference_range_select_out, 16'h2);
		reset_flag_clear_cmd_in = 1;
		step(1);
		reset_flag_clear_cmd_in = 0;
		chk({state_out, reset_flag_out}, {LDPIC_ST_NORMAL, 1'b0});
		supply_uv_in = 1;
		step(4);
		chk({state_out, err_oe_out, reset_flag_out}, {LDPIC_ST_RESET, 2'b11});
		supply_uv_in = 0;
		step(5);
		chk(state_out, LDPIC_ST_INIT);
		step(2);
		chk(state_out, LDPIC_ST_INIT);
		step(1);
		chk(state_out, LDPIC_ST_NORMAL);
		$display("power test done");
	endtask
	// Range table, enables, codes, then reload from the host
	task automatic t_cfg;
		range_wr_in = 1;
		for (int i = 0; i < 4; i++) begin
			reference_range_select_in = 2'(i);
			step(1);
			chk(full_range_mult_out, 16'h40 << i);
		end
		range_wr_in = 0;
		channel_enable_bit_in = 12'ha5a;
		enable_wr_in = 1;
		code_channel_in = 4'hb;
		channel_current_code_in = 6'h3f;
		code_wr_in = 1;
		step(1);
		{enable_wr_in, code_wr_in} = 2'b00;
		chk(channel_enable_out, 16'ha5a);
		chk(channel_current_code_out[71:66], 16'h3f);
		go = 1;
		step(1);
		go = 0;
		step(1);
		chk(register_reload_cmd_out, 16'h1);
		step(1);
		chk({register_reload_cmd_out, reset_flag_out, channel_enable_out}, 16'h1000);
		chk({reference_range_select_out, channel_current_code_out[71:66]}, 16'h80);
		$display("config test done");
	endtask
	// Low supply warning, diagnostic gating, fault clear, diagnostic pulse
	task automatic t_low;
		low_supply_threshold_in = 4'h1;
		adc_supply_code_in = 8'h10;
		threshold_wr_in = 1;
		step(1);
		threshold_wr_in = 0;
		step(60);
		chk({low_supply_warning_flag_out, open_diag_enable_out, short_diag_enable_out}, 16'h4);
		adc_supply_code_in = 8'hff;
		step(60);
		chk({low_supply_warning_flag_out, open_diag_enable_out, short_diag_enable_out}, 16'h7);
		fault_clear_cmd_in = 1;
		step(1);
		fault_clear_cmd_in = 0;
		chk({low_supply_warning_flag_out, fault_clear_cmd_out, supply_result_out}, 16'hff);
		chk({err_out, reset_flag_clear_cmd_out, low_supply_threshold_out, diag_pulse_width_sel_out},
			16'h10);
		{pulse_width_wr_in, diag_start_in} = 2'b11;
		step(1);
		{pulse_width_wr_in, diag_start_in} = 2'b00;
		step(1);
		chk(diag_pulse_out, 16'h1);
		step(8);
		chk(diag_pulse_out, 16'h1);
		step(1);
		chk(diag_pulse_out, 16'h0);
		// Regulator undervoltage with channels on: enables drop as reset is entered
		channel_enable_bit_in = 12'hfff;
		enable_wr_in = 1;
		step(1);
		enable_wr_in = 0;
		ldo_uv_in = 1;
		step(3);
		chk({err_oe_out, state_out, channel_enable_out}, 16'h4000);
		ldo_uv_in = 0;
		$display("supply test done");
	endtask
	// Main sequence
	initial begin
		t_power();
		t_cfg();
		t_low();
		test_done();
	end
	// Watchdog against a hang
	initial begin
		#50us;
		errors++;
		test_done();
	end
endmodule // ldpic_top_tb
`default_nettype wire
